// file: inc/msc_pkg.sv
// register map, field positions and reset values of the meter status and
// control bank; shared by the bank and its verification environment
package msc_pkg;

  localparam int unsigned DW = 24;
  localparam int unsigned AW = 8;

  // printed offsets are word indices; byte address is four times the index
  localparam logic [5:0] IDX_FLAGS = 6'h0F;
  localparam logic [5:0] IDX_MASK  = 6'h1A;
  localparam logic [5:0] IDX_TEMP  = 6'h1B;
  localparam logic [5:0] IDX_CTRL  = 6'h1C;
  localparam logic [5:0] IDX_EPLS  = 6'h1D;
  localparam logic [5:0] IDX_SPLS  = 6'h1E;
  localparam logic [5:0] IDX_QPLS  = 6'h1F;
  localparam logic [1:0] BYTE_LSB  = 2'h0;

  localparam logic [DW-1:0] FLAGS_RST = 24'h000001;
  localparam logic [DW-1:0] MASK_RST  = 24'h000000;
  localparam logic [DW-1:0] CTRL_RST  = 24'h000000;
  localparam logic [DW-1:0] ZERO_RST  = 24'h000000;

  // event flag bit positions
  localparam int unsigned B_LOW_RATE_DONE = 23;
  localparam int unsigned B_CUR2_RANGE    = 22;
  localparam int unsigned B_VOLT2_RANGE   = 21;
  localparam int unsigned B_SAMPLE_DONE   = 20;
  localparam int unsigned B_CUR2_RMS      = 19;
  localparam int unsigned B_VOLT2_RMS     = 18;
  localparam int unsigned B_CUR1_RANGE    = 17;
  localparam int unsigned B_VOLT1_RANGE   = 16;
  localparam int unsigned B_ENERGY2       = 15;
  localparam int unsigned B_CUR1_RMS      = 14;
  localparam int unsigned B_VOLT1_RMS     = 13;
  localparam int unsigned B_ENERGY1       = 12;
  localparam int unsigned B_CUR1_FAULT    = 11;
  localparam int unsigned B_VOLT1_DIP     = 10;
  localparam int unsigned B_CUR2_FAULT    = 9;
  localparam int unsigned B_VOLT2_DIP     = 8;
  localparam int unsigned B_TEMP_NEW      = 7;
  localparam int unsigned B_VOLT2_OSC     = 6;
  localparam int unsigned B_CUR2_OSC      = 5;
  localparam int unsigned B_VOLT1_OSC     = 4;
  localparam int unsigned B_CUR1_OSC      = 3;
  localparam int unsigned B_LOW_SUPPLY    = 2;
  localparam int unsigned B_FREQ_NEW      = 1;
  localparam int unsigned B_BAD_CMD_N     = 0;

  // control field positions
  localparam int unsigned C_PHASE_HI  = 23;
  localparam int unsigned C_PHASE_LO  = 16;
  localparam int unsigned C_CUR2_GAIN = 12;
  localparam int unsigned C_STOP      = 8;
  localparam int unsigned C_CUR1_GAIN = 5;
  localparam int unsigned C_IRQ_OD    = 4;
  localparam int unsigned C_CLK_OFF   = 2;
  localparam int unsigned C_OSC_OFF   = 1;
  // writable control bits; the stop bit is a strobe and reads as zero
  localparam logic [DW-1:0] CTRL_WMASK = 24'hFF1036;

  // temperature gain: unsigned, binary point right of bit 22
  localparam int unsigned TGAIN_FRAC = 22;

endpackage

// file: logic/msc_regs.sv
// status, interrupt mask, control, temperature and pulse source registers
// of a two-channel metering device, reached by software over APB.
// assumes the datapath gives one-cycle event pulses and level conditions,
// all synchronous to pclk.
//
// What this block does
// - write one clears flag once condition gone
// - writing zero leaves a flag unchanged
// - only enabled flags drive the interrupt pin
// - bit 23 marks low-rate results or completion
// - bit 20 marks sample-rate results updated
// - bits 22,21,17,16 mark instantaneous overflow
// - bits 19,18,14,13 mark RMS overflow
// - bits 15,12 mark average power overflow
// - bits 11..8 mark faults and dips
// - bit 7 marks new temperature result
// - bits 6..3 mark modulator oscillation
// - low supply flag held until high threshold
// - bit 1 marks frequency ratio update
// - bit 0 drops on invalid command
// - temperature is signed, point right of bit 16
// - temperature rescaled by host gain and offset
// - pulse sources are signed fractions driving outputs
// - control 23..16 hold channel-2 phase delay
// - gain bits select 250mV or 50mV range
// - control bit 8 one stops memory commands
// - control bit 4 selects open-drain interrupt
// - bits 2,1 disable clock out, oscillator
`timescale 1ns/100ps

module msc_regs (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [msc_pkg::AW-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // datapath events: one-cycle pulses, bit positions as in event_flags
  input  wire logic [msc_pkg::DW-1:0]  evt_set,
  // datapath conditions still present, same positions
  input  wire logic [msc_pkg::DW-1:0]  cond_active,
  input  wire logic                    bad_command,
  // supply monitor comparators
  input  wire logic                    supply_below_low,
  input  wire logic                    supply_above_high,
  // raw temperature and its scaling
  input  wire logic [msc_pkg::DW-1:0]  temp_raw,
  input  wire logic                    temp_raw_valid,
  input  wire logic [msc_pkg::DW-1:0]  temp_gain,
  input  wire logic [msc_pkg::DW-1:0]  temp_offset,
  // pulse source values from the energy datapath
  input  wire logic [msc_pkg::DW-1:0]  active_pwr_in,
  input  wire logic [msc_pkg::DW-1:0]  apparent_pwr_in,
  input  wire logic [msc_pkg::DW-1:0]  reactive_pwr_in,
  input  wire logic                    pulse_in_valid,
  // pulse generator drive
  output logic      [msc_pkg::DW-1:0]  active_pulse_src,
  output logic      [msc_pkg::DW-1:0]  apparent_pulse_src,
  output logic      [msc_pkg::DW-1:0]  reactive_pulse_src,
  // control outputs
  output logic      [7:0]              ch2_phase_delay,
  output logic                         cur1_range_select,
  output logic                         cur2_range_select,
  output logic                         irq_open_drain_sel,
  output logic                         host_clk_out_off,
  output logic                         xtal_osc_off,
  output logic                         eeprom_stop,
  // interrupt pin, active low
  output logic                         irq_n_out,
  output logic                         irq_n_oe
);

  localparam int unsigned DW = msc_pkg::DW;

  // ==========================================================================
  // apb decode
  // ==========================================================================
  logic [DW-1:0] flags_q, flags_d;
  logic [DW-1:0] mask_q;
  logic [DW-1:0] ctrl_q;
  logic [DW-1:0] temp_q;
  logic [DW-1:0] epls_q, spls_q, qpls_q;
  logic          supply_low_q, supply_low_d;
  logic          stop_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;

  wire logic [5:0] idx      = paddr[msc_pkg::AW-1:2];
  wire logic       aligned  = paddr[1:0] == msc_pkg::BYTE_LSB;
  wire logic       setup    = psel & ~penable;
  wire logic       access   = psel & penable & pready_q;
  wire logic       wr       = access & pwrite;
  wire logic       hit_flag = aligned & (idx == msc_pkg::IDX_FLAGS);
  wire logic       hit_mask = aligned & (idx == msc_pkg::IDX_MASK);
  wire logic       hit_temp = aligned & (idx == msc_pkg::IDX_TEMP);
  wire logic       hit_ctrl = aligned & (idx == msc_pkg::IDX_CTRL);
  wire logic       hit_epls = aligned & (idx == msc_pkg::IDX_EPLS);
  wire logic       hit_spls = aligned & (idx == msc_pkg::IDX_SPLS);
  wire logic       hit_qpls = aligned & (idx == msc_pkg::IDX_QPLS);
  wire logic       hit_ro   = hit_temp | hit_epls | hit_spls | hit_qpls;
  wire logic       hit_any  = hit_flag | hit_mask | hit_ctrl | hit_ro;
  // writes to read-only words are refused as well as unmapped addresses
  wire logic       bad_acc  = ~hit_any | (pwrite & hit_ro);

  wire logic [DW-1:0] wdata   = pwdata[DW-1:0];
  wire logic          wr_flag = wr & hit_flag;
  wire logic          wr_mask = wr & hit_mask;
  wire logic          wr_ctrl = wr & hit_ctrl;

  // unmapped and misaligned words read as zero
  wire logic [DW-1:0] rd_word =
    hit_flag ? flags_q :
    hit_mask ? mask_q  :
    hit_ctrl ? ctrl_q  :
    hit_temp ? temp_q  :
    hit_epls ? epls_q  :
    hit_spls ? spls_q  :
    hit_qpls ? qpls_q  : msc_pkg::ZERO_RST;

  // no wait state: read data is captured in setup, so it is stable
  // through the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & bad_acc;
      if (setup && !pwrite) begin
        prdata_q <= {{(32-DW){1'b0}}, rd_word};
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // temperature result
  // ==========================================================================
  // scaling costs one pipeline stage so the multiplier never meets the adder
  // in one 4 ns cycle
  logic [DW-1:0]   temp_prod_q;
  logic            temp_prod_vld_q;
  logic            temp_new_q;

  wire logic signed [DW:0]     raw_s  = {temp_raw[DW-1], temp_raw};
  wire logic signed [DW:0]     gain_s = {1'b0, temp_gain};
  wire logic signed [2*DW+1:0] prod_w = raw_s * gain_s;
  wire logic [DW-1:0]          prod_shift =
    prod_w[msc_pkg::TGAIN_FRAC +: DW];
  wire logic [DW-1:0]          temp_scaled =
    temp_prod_q + temp_offset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_prod_q     <= msc_pkg::ZERO_RST;
      temp_prod_vld_q <= 1'b0;
      temp_q          <= msc_pkg::ZERO_RST;
      temp_new_q      <= 1'b0;
    end else begin
      temp_prod_vld_q <= temp_raw_valid;
      temp_new_q      <= temp_prod_vld_q;
      if (temp_raw_valid) begin
        temp_prod_q <= prod_shift;
      end
      if (temp_prod_vld_q) begin
        // signed word, eight integer bits above sixteen fraction bits
        temp_q <= temp_scaled;
      end
    end
  end

  // ==========================================================================
  // pulse sources
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epls_q <= msc_pkg::ZERO_RST;
      spls_q <= msc_pkg::ZERO_RST;
      qpls_q <= msc_pkg::ZERO_RST;
    end else if (pulse_in_valid) begin
      epls_q <= active_pwr_in;
      spls_q <= apparent_pwr_in;
      qpls_q <= reactive_pwr_in;
    end
  end

  assign active_pulse_src   = epls_q;
  assign apparent_pulse_src = spls_q;
  assign reactive_pulse_src = qpls_q;

  // ==========================================================================
  // event flags
  // ==========================================================================
  // the low supply flag keeps its condition alive until the high threshold
  // is crossed, giving the hysteresis the comparators alone do not have
  always_comb begin
    supply_low_d = supply_low_q;
    if (supply_below_low) begin
      supply_low_d = 1'b1;
    end else if (supply_above_high) begin
      supply_low_d = 1'b0;
    end
  end

  // set sources: bits 23..8, 6..3 and 1 from the datapath, 7 and 2 from here
  logic [DW-1:0] set_vec;
  logic [DW-1:0] hold_vec;
  always_comb begin
    set_vec = msc_pkg::ZERO_RST;
    // datapath pulses pass straight through, one flag per position;
    // spelled out bit by bit so a moved position shows in one place
    // results ready, low rate and sample rate
    set_vec[msc_pkg::B_LOW_RATE_DONE] =
      evt_set[msc_pkg::B_LOW_RATE_DONE];
    set_vec[msc_pkg::B_SAMPLE_DONE] =
      evt_set[msc_pkg::B_SAMPLE_DONE];
    // instantaneous overflow
    set_vec[msc_pkg::B_CUR2_RANGE] =
      evt_set[msc_pkg::B_CUR2_RANGE];
    set_vec[msc_pkg::B_VOLT2_RANGE] =
      evt_set[msc_pkg::B_VOLT2_RANGE];
    set_vec[msc_pkg::B_CUR1_RANGE] =
      evt_set[msc_pkg::B_CUR1_RANGE];
    set_vec[msc_pkg::B_VOLT1_RANGE] =
      evt_set[msc_pkg::B_VOLT1_RANGE];
    // rms overflow
    set_vec[msc_pkg::B_CUR2_RMS] =
      evt_set[msc_pkg::B_CUR2_RMS];
    set_vec[msc_pkg::B_VOLT2_RMS] =
      evt_set[msc_pkg::B_VOLT2_RMS];
    set_vec[msc_pkg::B_CUR1_RMS] =
      evt_set[msc_pkg::B_CUR1_RMS];
    set_vec[msc_pkg::B_VOLT1_RMS] =
      evt_set[msc_pkg::B_VOLT1_RMS];
    // average power overflow
    set_vec[msc_pkg::B_ENERGY2] =
      evt_set[msc_pkg::B_ENERGY2];
    set_vec[msc_pkg::B_ENERGY1] =
      evt_set[msc_pkg::B_ENERGY1];
    // current faults and voltage dips
    set_vec[msc_pkg::B_CUR1_FAULT] =
      evt_set[msc_pkg::B_CUR1_FAULT];
    set_vec[msc_pkg::B_VOLT1_DIP] =
      evt_set[msc_pkg::B_VOLT1_DIP];
    set_vec[msc_pkg::B_CUR2_FAULT] =
      evt_set[msc_pkg::B_CUR2_FAULT];
    set_vec[msc_pkg::B_VOLT2_DIP] =
      evt_set[msc_pkg::B_VOLT2_DIP];
    // modulator oscillation
    set_vec[msc_pkg::B_VOLT2_OSC] =
      evt_set[msc_pkg::B_VOLT2_OSC];
    set_vec[msc_pkg::B_CUR2_OSC] =
      evt_set[msc_pkg::B_CUR2_OSC];
    set_vec[msc_pkg::B_VOLT1_OSC] =
      evt_set[msc_pkg::B_VOLT1_OSC];
    set_vec[msc_pkg::B_CUR1_OSC] =
      evt_set[msc_pkg::B_CUR1_OSC];
    // frequency ratio update
    set_vec[msc_pkg::B_FREQ_NEW] =
      evt_set[msc_pkg::B_FREQ_NEW];
    // internal sources
    set_vec[msc_pkg::B_TEMP_NEW]   = temp_new_q;
    set_vec[msc_pkg::B_LOW_SUPPLY] = supply_below_low;
    set_vec[msc_pkg::B_BAD_CMD_N]  = 1'b0;
    // a condition still present blocks its clear
    hold_vec = cond_active;
    hold_vec[msc_pkg::B_LOW_SUPPLY] = supply_low_q;
    hold_vec[msc_pkg::B_BAD_CMD_N]  = 1'b0;
  end

  wire logic [DW-1:0] clr_vec = wr_flag ?
    (wdata & ~hold_vec) : msc_pkg::ZERO_RST;
  // a zero in the write data clears nothing
  wire logic [DW-1:0] kept    = flags_q & ~clr_vec;

  always_comb begin
    // event wins over a clear landing in the same cycle
    flags_d = kept | set_vec;
    // bit 0 runs its own set and restore; an invalid command wins
    if (bad_command) begin
      flags_d[msc_pkg::B_BAD_CMD_N] = 1'b0;
    end else if (wr_flag && wdata[msc_pkg::B_BAD_CMD_N]) begin
      flags_d[msc_pkg::B_BAD_CMD_N] = 1'b1;
    end else begin
      flags_d[msc_pkg::B_BAD_CMD_N] = flags_q[msc_pkg::B_BAD_CMD_N];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q      <= msc_pkg::FLAGS_RST;
      supply_low_q <= 1'b0;
    end else begin
      flags_q      <= flags_d;
      supply_low_q <= supply_low_d;
    end
  end

  // ==========================================================================
  // mask and control
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= msc_pkg::MASK_RST;
      ctrl_q <= msc_pkg::CTRL_RST;
      stop_q <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask_q <= wdata;
      end
      // the stop bit is masked off here; it lives only as a strobe
      if (wr_ctrl) begin
        ctrl_q <= wdata & msc_pkg::CTRL_WMASK;
      end
      // a zero write leaves any command sequence running
      stop_q <= wr_ctrl & wdata[msc_pkg::C_STOP];
    end
  end

  assign ch2_phase_delay    =
    ctrl_q[msc_pkg::C_PHASE_HI:msc_pkg::C_PHASE_LO];
  // zero selects the 250mV range, one the 50mV range
  assign cur1_range_select  = ctrl_q[msc_pkg::C_CUR1_GAIN];
  assign cur2_range_select  = ctrl_q[msc_pkg::C_CUR2_GAIN];
  assign irq_open_drain_sel = ctrl_q[msc_pkg::C_IRQ_OD];
  assign host_clk_out_off   = ctrl_q[msc_pkg::C_CLK_OFF];
  assign xtal_osc_off       = ctrl_q[msc_pkg::C_OSC_OFF];
  assign eeprom_stop        = stop_q;

  // ==========================================================================
  // interrupt pin
  // ==========================================================================
  // the pin follows next-state flags, so it moves with the flag register
  // bit 0 is active low, so its request is the zero state
  wire logic [DW-1:0] req_vec =
    {flags_d[DW-1:1], ~flags_d[msc_pkg::B_BAD_CMD_N]};
  wire logic irq_act_d = |(req_vec & mask_q);
  wire logic od_sel_d  = wr_ctrl ? wdata[msc_pkg::C_IRQ_OD] :
                                   ctrl_q[msc_pkg::C_IRQ_OD];

  logic irq_out_q;
  logic irq_oe_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_q <= 1'b1;
      irq_oe_q  <= 1'b1;
    end else begin
      // open drain only pulls low; push-pull always drives
      irq_out_q <= od_sel_d ? 1'b0 : ~irq_act_d;
      irq_oe_q  <= od_sel_d ? irq_act_d : 1'b1;
    end
  end

  assign irq_n_out = irq_out_q;
  assign irq_n_oe  = irq_oe_q;

endmodule

// file: test/msc_chk.sv
// concurrent checks on the apb side and control outputs of msc_regs
// assumes port names of msc_regs; bound by name below
`timescale 1ns/100ps

module msc_chk (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [msc_pkg::AW-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // pulse sources
  input wire logic [msc_pkg::DW-1:0] active_pwr_in,
  input wire logic                   pulse_in_valid,
  input wire logic [msc_pkg::DW-1:0] active_pulse_src,
  // control and pin
  input wire logic [7:0]             ch2_phase_delay,
  input wire logic                   cur1_range_select,
  input wire logic                   cur2_range_select,
  input wire logic                   irq_open_drain_sel,
  input wire logic                   host_clk_out_off,
  input wire logic                   xtal_osc_off,
  input wire logic                   eeprom_stop,
  input wire logic                   irq_n_out,
  input wire logic                   irq_n_oe
);
  // ======================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl_wr = psel && penable && pready && pwrite && paddr == 8'h70;

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_bad_align: assert property (psel && !penable && paddr[1:0] != 2'h0
    |=> pready && pslverr) else $error("misaligned access accepted");
  a_phase_field:
    assert property (ctl_wr |=> ch2_phase_delay == $past(pwdata[23:16]))
    else $error("phase delay not taken");
  a_gain_bits:
    assert property (ctl_wr |=> cur1_range_select == $past(pwdata[5])
      && cur2_range_select == $past(pwdata[12])) else $error("gain bits");
  a_stop_pulse:
    assert property (ctl_wr && pwdata[8] |=> eeprom_stop)
    else $error("stop strobe missing");
  a_stop_quiet:
    assert property (!(ctl_wr && pwdata[8]) |=> !eeprom_stop)
    else $error("stop strobe without cause");
  a_drain_low:
    assert property (irq_open_drain_sel && $past(irq_open_drain_sel)
      |-> !irq_n_out) else $error("open drain drives high");
  a_push_oe:
    assert property (!irq_open_drain_sel && !$past(irq_open_drain_sel)
      |-> irq_n_oe) else $error("push-pull not enabled");
  a_clk_osc:
    assert property (ctl_wr |=> host_clk_out_off == $past(pwdata[2])
      && xtal_osc_off == $past(pwdata[1])) else $error("clock bits");
  a_pulse_copy:
    assert property (pulse_in_valid
      |=> active_pulse_src == $past(active_pwr_in))
    else $error("pulse source not copied");
endmodule

bind msc_regs msc_chk msc_chk_inst (.*);

// file: test/msc_host.sv
// apb host model: one transfer at a time, request held until pready
// assumes the slave answers with registered pready, prdata, pslverr
`timescale 1ns/100ps

module msc_host (
  // clock
  input  wire logic        pclk,
  // requester side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // completer side
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ======================================
  // transfer
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // idle cycle at the end so no signal is assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows no stale value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

// file: test/tb_top.sv
// self-checking bench for msc_regs; host model drives apb
// assumes msc_chk is bound in its own file
`timescale 1ns/100ps

module tb_top;
  // ======================================
  // signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, ch2_phase_delay;
  logic [31:0] pwdata, prdata, rd, v;
  logic [31:0] seed = 32'h0000001C;
  logic [23:0] evt_set, cond_active, temp_raw, temp_gain, temp_offset, ev;
  logic [23:0] active_pwr_in, apparent_pwr_in, reactive_pwr_in;
  logic [23:0] active_pulse_src, apparent_pulse_src, reactive_pulse_src;
  logic        bad_command, supply_below_low, supply_above_high;
  logic        temp_raw_valid, pulse_in_valid, eeprom_stop;
  logic        cur1_range_select, cur2_range_select, irq_open_drain_sel;
  logic        host_clk_out_off, xtal_osc_off, irq_n_out, irq_n_oe;
  logic [7:0]  bad_addr [3] = '{8'h00, 8'h3D, 8'hFC};
  int          failures = 0;
  int          total_checks = 0;

  msc_regs msc_regs_inst (.*);
  msc_host msc_host_inst (.*);

  always #2 pclk = ~pclk;

  // ======================================
  // helpers
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_temp(logic [23:0] r, g, o);
    logic signed [48:0] p;
    p = $signed(r) * $signed({1'b0, g});
    return {8'h00, p[45:22] + o};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    msc_host_inst.xfer(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    msc_host_inst.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, x);
  endtask

  task automatic pulse(input logic [23:0] b);
    evt_set <= b;
    @(posedge pclk);
    evt_set <= '0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic conclude();
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    conclude();
  end

  // ======================================
  // scenarios
  initial begin
    {evt_set, cond_active, temp_raw, temp_gain, temp_offset} = '0;
    {active_pwr_in, apparent_pwr_in, reactive_pwr_in, bad_command} = '0;
    {supply_below_low, supply_above_high, temp_raw_valid} = '0;
    pulse_in_valid = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h3C, 32'h1);
    rdc(8'h68, 32'h0);
    rdc(8'h70, 32'h0);
    wr(8'h68, 32'h00FFFFFF);
    for (int b = 1; b < 24; b++) begin
      ev = 24'h1 << b;
      if (24'hFFFF7A & ev) begin
        pulse(ev);
        rdc(8'h3C, {8'h0, ev | 24'h1});
        chk({31'h0, irq_n_out}, 32'h0);
        cond_active <= ev;
        wr(8'h3C, {8'h0, ev});
        rdc(8'h3C, {8'h0, ev | 24'h1});
        cond_active <= '0;
        wr(8'h3C, {8'h0, ~ev});
        rdc(8'h3C, {8'h0, ev | 24'h1});
        wr(8'h3C, {8'h0, ev});
        rdc(8'h3C, 32'h1);
        chk({31'h0, irq_n_out}, 32'h1);
      end
    end
    pulse(24'h100000);
    fork
      wr(8'h3C, 32'h100000);
      begin
        @(posedge pclk);
        evt_set <= 24'h100000;
        @(posedge pclk);
        evt_set <= '0;
      end
    join
    rdc(8'h3C, 32'h100001);
    wr(8'h3C, 32'h100000);
    wr(8'h68, 32'h0);
    pulse(24'h800000);
    chk({31'h0, irq_n_out}, 32'h1);
    wr(8'h3C, 32'h800000);
    bad_command <= 1'b1;
    pulse(24'h0);
    bad_command <= 1'b0;
    rdc(8'h3C, 32'h0);
    wr(8'h3C, 32'h1);
    supply_below_low <= 1'b1;
    pulse(24'h0);
    supply_below_low <= 1'b0;
    wr(8'h3C, 32'h4);
    rdc(8'h3C, 32'h5);
    supply_above_high <= 1'b1;
    pulse(24'h0);
    supply_above_high <= 1'b0;
    wr(8'h3C, 32'h4);
    rdc(8'h3C, 32'h1);
    repeat (4) begin
      v = nxt();
      {temp_raw, temp_offset} <= {v[23:0], v[31:8]};
      temp_gain <= {v[7:0], v[31:16]};
      {active_pwr_in, apparent_pwr_in, reactive_pwr_in} <=
        {v[23:0], v[31:8], ~v[23:0]};
      {temp_raw_valid, pulse_in_valid} <= 2'b11;
      pulse(24'h0);
      {temp_raw_valid, pulse_in_valid} <= 2'b00;
      rdc(8'h6C, exp_temp(v[23:0], {v[7:0], v[31:16]}, v[31:8]));
      rdc(8'h3C, 32'h81);
      wr(8'h3C, 32'h80);
      rdc(8'h74, {8'h0, v[23:0]});
      rdc(8'h78, {8'h0, v[31:8]});
      rdc(8'h7C, {8'h0, ~v[23:0]});
      chk({8'h0, apparent_pulse_src}, {8'h0, v[31:8]});
      chk({8'h0, reactive_pulse_src}, {8'h0, ~v[23:0]});
      wr(8'h74, ~v);
      chk({31'h0, er}, 32'h1);
      rdc(8'h74, {8'h0, v[23:0]});
      v = nxt() | 32'h100;
      wr(8'h70, v);
      rdc(8'h70, {8'h0, v[23:0] & msc_pkg::CTRL_WMASK});
      wr(8'h70, v & 32'hFFFEFF);
      rdc(8'h70, {8'h0, v[23:0] & msc_pkg::CTRL_WMASK});
    end
    foreach (bad_addr[i]) begin
      rdc(bad_addr[i], 32'h0);
      chk({31'h0, er}, 32'h1);
    end
    // open drain: released while quiet, pulls low only on a request
    wr(8'h68, 32'h00FFFFFF);
    wr(8'h70, 32'h10);
    chk({30'h0, irq_n_oe, irq_n_out}, 32'h0);
    pulse(24'h100000);
    chk({30'h0, irq_n_oe, irq_n_out}, 32'h2);
    wr(8'h3C, 32'h100000);
    chk({30'h0, irq_n_oe, irq_n_out}, 32'h0);
    wr(8'h68, 32'h0);
    wr(8'h70, 32'h0);
    conclude();
  end
endmodule
